//--- rtl/clock_synth_pkg.sv
package clock_synth_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int RAMP_STEP_NS = 1000;
	localparam int RAMP_CYCLES = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Serial link
	// ------------------------------------------------------------
	localparam logic [7:0] SLAVE_ADDR = 8'hD2;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] ACK_SLOT = 4'h9;
	localparam logic [3:0] FIRST_DATA_IDX = 4'h6;
	localparam logic [3:0] LAST_DATA_IDX = 4'h9;
	localparam logic [3:0] IDX_SAT = 4'hA;

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	localparam int NUM_REGS = 4;
	localparam int REG_FREQ = 0;
	localparam int REG_CPU = 1;
	localparam int REG_BUS = 2;
	localparam int REG_REF = 3;
	localparam logic [7:0] FREQ_RST = 8'h02;
	localparam logic [7:0] CPU_RST = 8'h4F;
	localparam logic [7:0] BUS_RST = 8'hFF;
	localparam logic [7:0] REF_RST = 8'h37;
	localparam int CODE_HI = 7;
	localparam int CODE_LO = 4;
	localparam int FSRC_BIT = 3;
	localparam int MODE_HI = 1;
	localparam int MODE_LO = 0;
	localparam int USB_ALT_BIT = 6;
	localparam int PROC_HI = 3;
	localparam int FREE_BUS_BIT = 7;
	localparam int BUS_HI = 6;
	localparam int INTC_HI = 5;
	localparam int INTC_LO = 4;
	localparam int REF_HI = 2;
	localparam logic [1:0] MODE_SS_OFF = 2'h0;
	localparam logic [1:0] MODE_TEST = 2'h1;
	localparam logic [1:0] MODE_SS_ON = 2'h2;
	localparam logic [1:0] MODE_HIZ = 2'h3;

	// ------------------------------------------------------------
	// Synchroniser lanes and frequency words
	// ------------------------------------------------------------
	localparam int SY_SCL = 0;
	localparam int SY_SDA = 1;
	localparam int SY_XTAL = 2;
	localparam int SY_PPROC = 3;
	localparam int SY_PBUS = 4;
	localparam int SY_PUSB = 5;
	localparam int SY_FS_LO = 6;
	localparam int SY_FS_HI = 7;
	localparam int SY_W = 8;
	localparam int CPU_FW = 14;
	localparam int PCI_FW = 13;
	localparam logic [CPU_FW-1:0] CPU_FREQ_RST = 14'h3070;
	localparam logic [PCI_FW-1:0] PCI_FREQ_RST = 13'h1022;

endpackage : clock_synth_pkg

//--- rtl/freq_table_rom.sv
`timescale 1ns/1ps
module freq_table_rom
	import clock_synth_pkg::*;
(
	input wire logic clk_in,
	input wire logic [4:0] addr_in,
	output logic [CPU_FW-1:0] cpu_q_out,
	output logic [PCI_FW-1:0] pci_q_out
);

	// ------------------------------------------------------------
	// Table in 10 kHz units, upper half is spread
	// ------------------------------------------------------------
	logic [CPU_FW+PCI_FW-1:0] word;

	always_comb
	begin
		case (addr_in)
			5'h00: word = {14'h1E78, 13'h0F3C};
			5'h01: word = {14'h1FA4, 13'h0FD2};
			5'h02: word = {14'h2C56, 13'h0EC4};
			5'h03: word = {14'h1A18, 13'h0D0C};
			5'h04: word = {14'h2DB4, 13'h0F3C};
			5'h05: word = {14'h2E4A, 13'h0F6E};
			5'h06: word = {14'h2FA8, 13'h0E92};
			5'h07: word = {14'h2710, 13'h0D02};
			5'h08: word = {14'h3138, 13'h0C4E};
			5'h09: word = {14'h34BC, 13'h0D2F};
			5'h0A: word = {14'h3584, 13'h0D61};
			5'h0B: word = {14'h361A, 13'h0D86};
			5'h0C: word = {14'h3778, 13'h0DDE};
			5'h0D: word = {14'h3840, 13'h0E10};
			5'h0E: word = {14'h3C8C, 13'h0F23};
			5'h0F: word = {14'h3412, 13'h0D02};
			5'h10: word = {14'h3070, 13'h1022};
			5'h11: word = {14'h1D4C, 13'h0EA6};
			5'h12: word = {14'h208A, 13'h1045};
			5'h13: word = {14'h1A18, 13'h0D0C};
			5'h14: word = {14'h2328, 13'h0BB8};
			5'h15: word = {14'h2BC0, 13'h0E92};
			5'h16: word = {14'h251C, 13'h0C5F};
			5'h17: word = {14'h2710, 13'h0D02};
			5'h18: word = {14'h2EE0, 13'h0FA0};
			5'h19: word = {14'h2CEC, 13'h0EF6};
			5'h1A: word = {14'h2AF8, 13'h0E53};
			5'h1B: word = {14'h2904, 13'h0DAC};
			5'h1C: word = {14'h36B0, 13'h0DAC};
			5'h1D: word = {14'h3A98, 13'h0EA6};
			5'h1E: word = {14'h3070, 13'h0C1C};
			default: word = {14'h3412, 13'h0D02};
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		cpu_q_out <= word[CPU_FW+PCI_FW-1:PCI_FW];
		pci_q_out <= word[PCI_FW-1:0];
	end

endmodule : freq_table_rom

//--- rtl/clock_synth_serial_config.sv
// Function
// - Apply data only after matching slave address
// - Bytes seven to ten load registers
// - Bits arrive most significant first
// - Source bit set ramps frequency to serial code; clear holds it
// - Four-bit code indexes frequency table
// - Two mode bits: spread, test, three-state
// - Code plus mode picks one of 32
// - Byte four enables alt and processor clocks
// - Byte five enables bus clocks
// - Byte six enables interrupt and reference clocks
// - Acknowledge every received byte once the slave address matches
// - Data line driven only for acknowledge
// - Data change with clock high is start/stop
// - Transfers framed by start and stop
// - Accept data after start plus address
// - Each bit takes effect at once
// - Early end keeps untouched registers
// - Stop or restart truncates transfer
// - Lines are open drain only
// - Command and count bytes ignored
// - Disabled clocks are driven low
// - Test mode bypasses the PLL
// - Frequency changes ramp smoothly
`timescale 1ns/1ps
module clock_synth_serial_config
	import clock_synth_pkg::*;
(
	input wire logic CLK_SYS_IN,
	input wire logic RST_N_IN,
	input wire logic SERIAL_CLOCK_LINE_IN,
	input wire logic SERIAL_DATA_LINE_IN,
	output logic SERIAL_DATA_LINE_OUT,
	output logic SERIAL_DATA_LINE_OE_OUT,
	input wire logic CRYSTAL_INPUT_IN,
	input wire logic PLL_PROC_IN,
	input wire logic PLL_BUS_IN,
	input wire logic PLL_USB_IN,
	input wire logic [1:0] FREQ_SELECT_PINS_IN,
	output logic [3:0] PROCESSOR_CLOCK_OUTS,
	output logic [6:0] STOPPABLE_BUS_CLOCKS_OUT,
	output logic FREE_BUS_CLOCK_OUT,
	output logic [1:0] INTERRUPT_CTRL_CLOCKS_OUT,
	output logic [2:0] REFERENCE_CLOCK_OUTS,
	output logic USB_ALT_CLOCK_OUT,
	output logic USB_FIXED_CLOCK_OUT,
	output logic CLOCK_OE_OUT,
	output logic FREQ_SOURCE_SELECT_OUT,
	output logic [1:0] FREQ_SELECT_PINS_OUT,
	output logic [1:0] MODE_OUT,
	output logic [CPU_FW-1:0] CPU_FREQ_OUT,
	output logic [PCI_FW-1:0] PCI_FREQ_OUT
);

	typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_ACK, ST_IGNORE} rx_state_e;

	function automatic logic gate(input logic en, input logic src);
		gate = en & src;
	endfunction : gate

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [SY_W-1:0] raw;
	logic [SY_W-1:0] s1_ff;
	logic [SY_W-1:0] s2_ff;
	logic [SY_W-1:0] s3_ff;
	logic [SY_W-1:0] filt_ff;
	logic [SY_W-1:0] prev_ff;

	assign raw = {FREQ_SELECT_PINS_IN, PLL_USB_IN, PLL_BUS_IN, PLL_PROC_IN,
		CRYSTAL_INPUT_IN, SERIAL_DATA_LINE_IN, SERIAL_CLOCK_LINE_IN};

	always_ff @(posedge CLK_SYS_IN)
	begin
		s1_ff <= raw;
		s2_ff <= s1_ff;
		s3_ff <= s2_ff;
	end

	genvar gi;
	generate
		for (gi = 0; gi < SY_W; gi++)
		begin : g_filt
			always_ff @(posedge CLK_SYS_IN)
			begin
				if (!RST_N_IN)
					filt_ff[gi] <= 1'b1;
				else if (s2_ff[gi] == s3_ff[gi])
					filt_ff[gi] <= s3_ff[gi];
				prev_ff[gi] <= filt_ff[gi];
			end
		end
	endgenerate

	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	assign scl = filt_ff[SY_SCL];
	assign sda = filt_ff[SY_SDA];
	assign scl_rise = scl & ~prev_ff[SY_SCL];
	assign scl_fall = ~scl & prev_ff[SY_SCL];
	assign start_det = scl & prev_ff[SY_SCL] & prev_ff[SY_SDA] & ~sda;
	assign stop_det = scl & prev_ff[SY_SCL] & ~prev_ff[SY_SDA] & sda;

	// ------------------------------------------------------------
	// Serial receiver
	// ------------------------------------------------------------
	rx_state_e st_ff;
	logic [3:0] bit_cnt_ff;
	logic [3:0] byte_idx_ff;
	logic [7:0] shift_ff;
	logic sda_oe_ff;
	logic sda_out_ff;

	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
		begin
			st_ff <= ST_IDLE;
			bit_cnt_ff <= 4'h0;
			byte_idx_ff <= 4'h0;
			shift_ff <= 8'h00;
			sda_oe_ff <= 1'b0;
		end
		else if (start_det)
		begin
			st_ff <= ST_RX;
			bit_cnt_ff <= 4'h0;
			byte_idx_ff <= 4'h0;
			sda_oe_ff <= 1'b0;
		end
		else if (stop_det)
		begin
			st_ff <= ST_IDLE;
			sda_oe_ff <= 1'b0;
		end
		else
		begin
			case (st_ff)
				ST_RX:
				begin
					if (scl_rise && bit_cnt_ff < BYTE_BITS)
					begin
						shift_ff <= {shift_ff[6:0], sda};
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
					end
					else if (scl_fall && bit_cnt_ff == BYTE_BITS)
					begin
						if (byte_idx_ff == 4'h0 && shift_ff != SLAVE_ADDR)
							st_ff <= ST_IGNORE;
						else
						begin
							st_ff <= ST_ACK;
							sda_oe_ff <= 1'b1;
						end
					end
				end
				ST_ACK:
				begin
					if (scl_rise)
						bit_cnt_ff <= ACK_SLOT;
					else if (scl_fall && bit_cnt_ff == ACK_SLOT)
					begin
						st_ff <= ST_RX;
						sda_oe_ff <= 1'b0;
						bit_cnt_ff <= 4'h0;
						if (byte_idx_ff != IDX_SAT)
							byte_idx_ff <= byte_idx_ff + 4'h1;
					end
				end
				ST_IGNORE:
					sda_oe_ff <= 1'b0;
				default:
					sda_oe_ff <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS_IN)
	begin
		sda_out_ff <= 1'b0;
	end

	// ------------------------------------------------------------
	// Control registers, written bit by bit
	// ------------------------------------------------------------
	logic [7:0] ctrl_ff [NUM_REGS];
	logic wr_en;
	logic [1:0] wr_sel;
	logic [2:0] wr_bit;

	assign wr_en = (st_ff == ST_RX) && scl_rise && !start_det && !stop_det
		&& bit_cnt_ff < BYTE_BITS && byte_idx_ff >= FIRST_DATA_IDX
		&& byte_idx_ff <= LAST_DATA_IDX;
	assign wr_sel = 2'(byte_idx_ff - FIRST_DATA_IDX);
	assign wr_bit = ~bit_cnt_ff[2:0];

	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
		begin
			ctrl_ff[REG_FREQ] <= FREQ_RST;
			ctrl_ff[REG_CPU] <= CPU_RST;
			ctrl_ff[REG_BUS] <= BUS_RST;
			ctrl_ff[REG_REF] <= REF_RST;
		end
		else if (wr_en)
			ctrl_ff[wr_sel][wr_bit] <= sda;
	end

	logic [1:0] mode;
	logic fsrc;
	logic hiz;
	logic test;

	assign mode = ctrl_ff[REG_FREQ][MODE_HI:MODE_LO];
	assign fsrc = ctrl_ff[REG_FREQ][FSRC_BIT];
	assign hiz = (mode == MODE_HIZ);
	assign test = (mode == MODE_TEST);

	// ------------------------------------------------------------
	// Frequency table and ramp
	// ------------------------------------------------------------
	logic [CPU_FW-1:0] tgt_cpu;
	logic [PCI_FW-1:0] tgt_pci;
	logic [CPU_FW-1:0] cpu_f_ff;
	logic [PCI_FW-1:0] pci_f_ff;
	logic [7:0] ramp_cnt_ff;
	logic ramp_tick;

	freq_table_rom u_rom (
		.clk_in(CLK_SYS_IN),
		.addr_in({mode[MODE_HI], ctrl_ff[REG_FREQ][CODE_HI:CODE_LO]}),
		.cpu_q_out(tgt_cpu),
		.pci_q_out(tgt_pci)
	);

	assign ramp_tick = (ramp_cnt_ff == 8'(RAMP_CYCLES - 1));

	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN || ramp_tick)
			ramp_cnt_ff <= 8'h00;
		else
			ramp_cnt_ff <= ramp_cnt_ff + 8'h01;
	end

	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
		begin
			cpu_f_ff <= CPU_FREQ_RST;
			pci_f_ff <= PCI_FREQ_RST;
		end
		else if (ramp_tick && fsrc)
		begin
			if (cpu_f_ff < tgt_cpu)
				cpu_f_ff <= cpu_f_ff + 14'h0001;
			else if (cpu_f_ff > tgt_cpu)
				cpu_f_ff <= cpu_f_ff - 14'h0001;
			if (pci_f_ff < tgt_pci)
				pci_f_ff <= pci_f_ff + 13'h0001;
			else if (pci_f_ff > tgt_pci)
				pci_f_ff <= pci_f_ff - 13'h0001;
		end
	end

	// ------------------------------------------------------------
	// Clock sources and output gating
	// ------------------------------------------------------------
	logic [1:0] xdiv_ff;
	logic udiv_ff;
	logic xtal;
	logic proc_src;
	logic bus_src;
	logic u48_src;
	logic u24_src;

	assign xtal = filt_ff[SY_XTAL];

	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
			xdiv_ff <= 2'h0;
		else if (xtal && !prev_ff[SY_XTAL])
			xdiv_ff <= xdiv_ff + 2'h1;
	end

	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
			udiv_ff <= 1'b0;
		else if (filt_ff[SY_PUSB] && !prev_ff[SY_PUSB])
			udiv_ff <= ~udiv_ff;
	end

	assign proc_src = test ? xdiv_ff[0] : filt_ff[SY_PPROC];
	assign bus_src = test ? xdiv_ff[1] : filt_ff[SY_PBUS];
	assign u48_src = test ? xdiv_ff[0] : filt_ff[SY_PUSB];
	assign u24_src = test ? xdiv_ff[1] : udiv_ff;

	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
		begin
			PROCESSOR_CLOCK_OUTS <= 4'h0;
			STOPPABLE_BUS_CLOCKS_OUT <= 7'h00;
			FREE_BUS_CLOCK_OUT <= 1'b0;
			INTERRUPT_CTRL_CLOCKS_OUT <= 2'h0;
			REFERENCE_CLOCK_OUTS <= 3'h0;
			USB_ALT_CLOCK_OUT <= 1'b0;
			USB_FIXED_CLOCK_OUT <= 1'b0;
			CLOCK_OE_OUT <= 1'b1;
		end
		else
		begin
			CLOCK_OE_OUT <= ~hiz;
			for (int i = 0; i <= PROC_HI; i++)
				PROCESSOR_CLOCK_OUTS[i] <= gate(ctrl_ff[REG_CPU][i] & ~hiz, proc_src);
			for (int i = 0; i <= BUS_HI; i++)
				STOPPABLE_BUS_CLOCKS_OUT[i] <= gate(ctrl_ff[REG_BUS][i] & ~hiz, bus_src);
			FREE_BUS_CLOCK_OUT <= gate(ctrl_ff[REG_BUS][FREE_BUS_BIT] & ~hiz, bus_src);
			for (int i = 0; i <= INTC_HI - INTC_LO; i++)
				INTERRUPT_CTRL_CLOCKS_OUT[i] <= gate(ctrl_ff[REG_REF][INTC_LO + i] & ~hiz, xtal);
			for (int i = 0; i <= REF_HI; i++)
				REFERENCE_CLOCK_OUTS[i] <= gate(ctrl_ff[REG_REF][i] & ~hiz, xtal);
			USB_ALT_CLOCK_OUT <= gate(ctrl_ff[REG_CPU][USB_ALT_BIT] & ~hiz, u24_src);
			USB_FIXED_CLOCK_OUT <= gate(~hiz, u48_src);
		end
	end

	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
		begin
			FREQ_SOURCE_SELECT_OUT <= 1'b0;
			FREQ_SELECT_PINS_OUT <= 2'h0;
			MODE_OUT <= MODE_SS_ON;
			CPU_FREQ_OUT <= CPU_FREQ_RST;
			PCI_FREQ_OUT <= PCI_FREQ_RST;
		end
		else
		begin
			FREQ_SOURCE_SELECT_OUT <= fsrc;
			FREQ_SELECT_PINS_OUT <= filt_ff[SY_FS_HI:SY_FS_LO];
			MODE_OUT <= mode;
			CPU_FREQ_OUT <= cpu_f_ff;
			PCI_FREQ_OUT <= pci_f_ff;
		end
	end

	assign SERIAL_DATA_LINE_OUT = sda_out_ff;
	assign SERIAL_DATA_LINE_OE_OUT = sda_oe_ff;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (!RST_N_IN);

	property p_addr_miss;
		(st_ff == ST_RX && scl_fall && bit_cnt_ff == BYTE_BITS && byte_idx_ff == 4'h0
			&& shift_ff != SLAVE_ADDR && !start_det && !stop_det) |=> st_ff == ST_IGNORE;
	endproperty
	a_addr_miss: assert property (p_addr_miss) else $error("bad address not ignored");

	property p_ack;
		(st_ff == ST_RX && scl_fall && bit_cnt_ff == BYTE_BITS && shift_ff == SLAVE_ADDR
			&& !start_det && !stop_det) |=> sda_oe_ff && st_ff == ST_ACK;
	endproperty
	a_ack: assert property (p_ack) else $error("no acknowledge");

	property p_drive_only_ack;
		sda_oe_ff |-> st_ff == ST_ACK && SERIAL_DATA_LINE_OUT == 1'b0;
	endproperty
	a_drive_only_ack: assert property (p_drive_only_ack) else $error("data driven out of ack");

	property p_bit_write;
		wr_en |=> ctrl_ff[$past(wr_sel)][$past(wr_bit)] == $past(sda);
	endproperty
	a_bit_write: assert property (p_bit_write) else $error("bit not applied");

	property p_hold;
		!wr_en |=> $stable(ctrl_ff[REG_FREQ]) && $stable(ctrl_ff[REG_CPU])
			&& $stable(ctrl_ff[REG_BUS]) && $stable(ctrl_ff[REG_REF]);
	endproperty
	a_hold: assert property (p_hold) else $error("register changed without write");

	property p_restart;
		start_det |=> st_ff == ST_RX && byte_idx_ff == 4'h0 && bit_cnt_ff == 4'h0;
	endproperty
	a_restart: assert property (p_restart) else $error("restart not honoured");

	property p_stop;
		stop_det && !start_det |=> st_ff == ST_IDLE && !sda_oe_ff;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not honoured");

	property p_hiz;
		hiz |=> !CLOCK_OE_OUT && PROCESSOR_CLOCK_OUTS == 4'h0;
	endproperty
	a_hiz: assert property (p_hiz) else $error("three-state not applied");

	property p_disabled_low;
		!ctrl_ff[REG_CPU][0] |=> !PROCESSOR_CLOCK_OUTS[0];
	endproperty
	a_disabled_low: assert property (p_disabled_low) else $error("disabled clock not low");

	property p_ramp;
		!ramp_tick |=> $stable(cpu_f_ff);
	endproperty
	a_ramp: assert property (p_ramp) else $error("frequency jumped");

	c_ack: cover property (sda_oe_ff && scl_rise);
	c_write_last: cover property (wr_en && byte_idx_ff == LAST_DATA_IDX);
	c_test: cover property (test && xtal && !prev_ff[SY_XTAL]);
	c_stop: cover property (stop_det && byte_idx_ff > FIRST_DATA_IDX);

endmodule : clock_synth_serial_config

//--- tb/serial_master_model.sv
`timescale 1ns/1ps
module serial_master_model
(
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_low_out,
	output logic sda_low_out
);
	localparam int HALF = 8;

	initial
	begin
		scl_low_out = 1'b0;
		sda_low_out = 1'b0;
	end

	task automatic pause(input int n);
		repeat (n) @(posedge clk_in);
	endtask : pause

	// ------------------------------------------------------------
	// Framing, from idle or as restart
	// ------------------------------------------------------------
	task automatic send_start();
		pause(2);
		sda_low_out <= 1'b0;
		pause(HALF);
		scl_low_out <= 1'b0;
		pause(HALF);
		sda_low_out <= 1'b1;
		pause(HALF);
		scl_low_out <= 1'b1;
	endtask : send_start

	task automatic send_stop();
		pause(2);
		sda_low_out <= 1'b1;
		pause(HALF);
		scl_low_out <= 1'b0;
		pause(HALF);
		sda_low_out <= 1'b0;
		pause(HALF);
	endtask : send_stop

	// ------------------------------------------------------------
	// Bits change only while clock is low
	// ------------------------------------------------------------
	task automatic send_bits(input logic [7:0] b, input int n);
		for (int i = 7; i > 7 - n; i--)
		begin
			pause(2);
			sda_low_out <= ~b[i];
			pause(HALF);
			scl_low_out <= 1'b0;
			pause(HALF);
			scl_low_out <= 1'b1;
		end
	endtask : send_bits

	task automatic send_byte(input logic [7:0] b, output logic ack);
		send_bits(b, 8);
		pause(2);
		sda_low_out <= 1'b0;
		pause(HALF);
		scl_low_out <= 1'b0;
		pause(HALF / 2);
		ack = ~sda_in;
		pause(HALF / 2);
		scl_low_out <= 1'b1;
	endtask : send_byte
endmodule : serial_master_model

//--- tb/clock_synth_serial_config_test.sv
`timescale 1ns/1ps
`define CHECK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, a); end end
module clock_synth_serial_config_test
	import clock_synth_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic xtal = 1'b0;
	logic [1:0] xcnt = 2'h0;
	logic pll_p = 1'b0;
	logic pll_b = 1'b0;
	logic pll_u = 1'b0;
	logic [1:0] fs_pins = 2'h0;
	logic [15:0] lfsr = 16'h5275;
	logic m_scl_low, m_sda_low, sda_out, sda_oe, free_bus, usb_alt, usb_fix, clk_oe, fsrc;
	logic [3:0] proc;
	logic [6:0] busc;
	logic [1:0] intc, fs_out, mode;
	logic [2:0] refc;
	logic [CPU_FW-1:0] cpu_f, cpu_hold;
	logic [PCI_FW-1:0] pci_f;
	logic [7:0] e3 = FREQ_RST, e4 = CPU_RST, e5 = BUS_RST, e6 = REF_RST;
	logic [7:0] n3, n4, n5, n6;
	logic [17:0] seen;
	int fail_count = 0;
	int comparisons = 0;
	int acks;
	wire scl_w = ~m_scl_low;
	wire sda_w = ~(m_sda_low | (sda_oe & ~sda_out));

	serial_master_model i_master (.clk_in(clk), .sda_in(sda_w), .scl_low_out(m_scl_low),
		.sda_low_out(m_sda_low));

	clock_synth_serial_config i_dut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n),
		.SERIAL_CLOCK_LINE_IN(scl_w), .SERIAL_DATA_LINE_IN(sda_w),
		.SERIAL_DATA_LINE_OUT(sda_out), .SERIAL_DATA_LINE_OE_OUT(sda_oe),
		.CRYSTAL_INPUT_IN(xtal), .PLL_PROC_IN(pll_p), .PLL_BUS_IN(pll_b), .PLL_USB_IN(pll_u),
		.FREQ_SELECT_PINS_IN(fs_pins), .PROCESSOR_CLOCK_OUTS(proc),
		.STOPPABLE_BUS_CLOCKS_OUT(busc), .FREE_BUS_CLOCK_OUT(free_bus),
		.INTERRUPT_CTRL_CLOCKS_OUT(intc), .REFERENCE_CLOCK_OUTS(refc),
		.USB_ALT_CLOCK_OUT(usb_alt), .USB_FIXED_CLOCK_OUT(usb_fix), .CLOCK_OE_OUT(clk_oe),
		.FREQ_SOURCE_SELECT_OUT(fsrc), .FREQ_SELECT_PINS_OUT(fs_out), .MODE_OUT(mode),
		.CPU_FREQ_OUT(cpu_f), .PCI_FREQ_OUT(pci_f));

	// ------------------------------------------------------------
	// Clock and random sources
	// ------------------------------------------------------------
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next

	function automatic logic [17:0] exp_vec(input logic [7:0] b4, b5, b6, input logic [1:0] m);
		return {b4[6], b5, b4[3:0], b6[5:4], b6[2:0]} & {18{m != MODE_HIZ}};
	endfunction : exp_vec

	always #10 clk = ~clk;

	always @(posedge clk)
	begin
		lfsr <= lfsr_next(lfsr);
		pll_p <= lfsr[0];
		pll_b <= lfsr[3];
		pll_u <= lfsr[7];
		xcnt <= xcnt + 2'h1;
		xtal <= xcnt[1];
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test

	task automatic rnd_regs(input logic [1:0] m);
		n3 = {lfsr[7:4], 2'b00, m};
		n4 = lfsr[15:8] & 8'h4F;
		n5 = lfsr[7:0] ^ lfsr[15:8];
		n6 = lfsr[11:4] & 8'h37;
	endtask : rnd_regs

	task automatic frame(input logic [7:0] addr, input int nbytes, input int nbits);
		logic [7:0] fr [10];
		logic a;
		fr = '{addr, 8'hA5, 8'h04, 8'h11, 8'h22, 8'h33, n3, n4, n5, n6};
		acks = 0;
		i_master.send_start();
		for (int i = 0; i < nbytes; i++)
		begin
			i_master.send_byte(fr[i], a);
			if (a === 1'b1)
				acks++;
		end
		if (nbits > 0)
			i_master.send_bits(fr[nbytes], nbits);
	endtask : frame

	task automatic check_state(input string nm);
		seen = '0;
		repeat (64) @(negedge clk) seen |= {usb_alt, free_bus, busc, proc, intc, refc};
		`CHECK("clock outputs", exp_vec(e4, e5, e6, e3[1:0]), seen)
		`CHECK("mode", e3[1:0], mode)
		`CHECK("source", e3[3], fsrc)
		`CHECK("clock oe", (e3[1:0] != MODE_HIZ), clk_oe)
		$display("test %s done", nm);
	endtask : check_state

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial
	begin
		repeat (60000) @(posedge clk);
		fail_count++;
		finish_test();
	end

	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		fs_pins <= lfsr[9:8];
		repeat (4) @(posedge clk);
		`CHECK("cpu freq", CPU_FREQ_RST, cpu_f)
		`CHECK("pci freq", PCI_FREQ_RST, pci_f)
		`CHECK("data oe", 1'b0, sda_oe)
		check_state("reset");
		for (int m = 0; m < 4; m++)
		begin
			rnd_regs(m[1:0]);
			frame(SLAVE_ADDR, 10, 0);
			i_master.send_stop();
			`CHECK("acks", 10, acks)
			{e3, e4, e5, e6} = {n3, n4, n5, n6};
			check_state("full frame");
		end
		rnd_regs(2'h1);
		frame(SLAVE_ADDR ^ 8'h04, 10, 0);
		i_master.send_stop();
		`CHECK("acks", 0, acks)
		check_state("wrong address");
		rnd_regs(2'h2);
		frame(SLAVE_ADDR, 6, 7);
		i_master.send_stop();
		`CHECK("acks", 6, acks)
		// Stop clock rise lands as bit 0, data held low
		e3 = {n3[7:1], 1'b0};
		check_state("partial byte");
		rnd_regs(2'h0);
		frame(SLAVE_ADDR, 8, 0);
		`CHECK("acks", 8, acks)
		{e3, e4} = {n3, n4};
		// Restart clock rise writes byte five bit 7 with data high
		e5[7] = 1'b1;
		frame(SLAVE_ADDR, 2, 0);
		i_master.send_stop();
		`CHECK("acks", 2, acks)
		check_state("restart");
		n3 = 8'h0A;
		frame(SLAVE_ADDR, 7, 0);
		i_master.send_stop();
		e3 = n3;
		check_state("serial source");
		repeat (300) @(posedge clk);
		`CHECK("cpu freq", CPU_FREQ_RST, cpu_f)
		`CHECK("pci freq", PCI_FREQ_RST, pci_f)
		n3 = 8'h88;
		frame(SLAVE_ADDR, 7, 0);
		i_master.send_stop();
		e3 = n3;
		repeat (3000) @(posedge clk);
		`CHECK("cpu ramp", 1'b1, (cpu_f > CPU_FREQ_RST && cpu_f < 14'h3138))
		`CHECK("pci ramp", 1'b1, (pci_f < PCI_FREQ_RST))
		n3 = 8'h80;
		frame(SLAVE_ADDR, 7, 0);
		i_master.send_stop();
		e3 = n3;
		cpu_hold = cpu_f;
		check_state("pin source");
		repeat (200) @(posedge clk);
		`CHECK("cpu hold", cpu_hold, cpu_f)
		`CHECK("pins", fs_pins, fs_out)
		finish_test();
	end
endmodule : clock_synth_serial_config_test
